//--- core/thermal_sensor_reg_access.sv
// Two-wire serial target giving word access to the temperature monitor registers.
// Assumes SCL and SDA are asynchronous pins and SCL is much slower than clk.
//
// Function
// - Answer address 0011 plus strap bits
// - Nine 16-bit registers, two-byte transfers only
// - Index byte then two data bytes write
// - Pointer kept; plain read returns current register
// - Bytes travel most significant bit first
// - Accept ack or nack after last byte
// - Pointer write-only; documented reset values
// - Feature, temperature, identity registers read-only
// - Feature bits 15:8 read zero
// - Flag 0: event output freezes in sleep
// - Flag 1: event output released in sleep
// - Feature bit 6 reports timeout window
// - Bus timeout works awake or asleep
// - Feature bit 5 don't-care, reads one
// - Feature bits 4:3 report resolution code
// - Feature bit 2 reports negative range
// - Feature bit 1 reports accuracy grade
// - Feature bit 0 reports event support
// - Sleep stops updates and events, bus answers
`timescale 1ns/1ps
`default_nettype none
module thermal_sensor_reg_access
	import thermal_sensor_pkg::*;
#(
	parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
	parameter logic [15:0] MAKER_CODE = 16'h1a2b, // Arbitrary value
	parameter logic [15:0] PART_CODE = 16'h3c01 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_addr_bit2,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit0,
	input wire logic temp_valid,
	input wire logic [15:0] temp_sample,
	input wire logic event_request,
	output logic event_active,
	output logic event_oe,
	output logic sensor_sleep_control
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	generate
		if (TIMEOUT_CYC < 16) begin : g_bad_timeout
			$error("TIMEOUT_CYC too small for the bus timeout");
		end
	endgenerate

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		bus_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rd;
		logic [1:0] bytenum;
		logic [7:0] index;
		logic [7:0] hold;
		logic oe;
		logic acked;
		logic [TW-1:0] tocnt;
		logic [15:0] ctrl;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] crit;
		logic [15:0] temp;
		logic [15:0] step;
	} tgt_state_t;

	tgt_state_t q;
	tgt_state_t n;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic timed_out;
	logic sleeping;
	logic [15:0] rd_word;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	// Unmapped indices read as zero rather than aliasing a register
	function automatic logic [15:0] read_word(input tgt_state_t s, input logic [7:0] idx);
		logic [15:0] w;
		w = 16'h0000;
		if (idx == IDX_FEATURE) begin
			w = FEATURE_RESET;
		end else if (idx == IDX_CONTROL) begin
			w = s.ctrl;
		end else if (idx == IDX_UPPER) begin
			w = s.upper;
		end else if (idx == IDX_LOWER) begin
			w = s.lower;
		end else if (idx == IDX_CRIT) begin
			w = s.crit;
		end else if (idx == IDX_TEMP) begin
			w = s.temp;
		end else if (idx == IDX_MAKER) begin
			w = MAKER_CODE;
		end else if (idx == IDX_PART) begin
			w = PART_CODE;
		end else if (idx == IDX_STEP) begin
			w = s.step;
		end
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Pin conditions seen on synchronised copies
	// ----------------------------------------------------------------
	assign scl_rise = q.scl_s2 & ~q.scl_s3;
	assign scl_fall = ~q.scl_s2 & q.scl_s3;
	assign start_seen = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
	assign stop_seen = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
	assign timed_out = (q.tocnt == TW'(TIMEOUT_CYC - 1)) & ~q.scl_s2;
	assign sleeping = q.ctrl[SLEEP_BIT];
	assign rd_word = read_word(q, q.index);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		n.scl_s1 = scl_in;
		n.scl_s2 = q.scl_s1;
		n.scl_s3 = q.scl_s2;
		n.sda_s1 = sda_in;
		n.sda_s2 = q.sda_s1;
		n.sda_s3 = q.sda_s2;
		n.strap_s1 = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
		n.strap_s2 = q.strap_s1;
		// Samples are dropped while asleep
		if (temp_valid && !sleeping) begin
			n.temp = temp_sample;
		end
		// Stuck-low clock watchdog runs regardless of sleep
		if (q.st != ST_IDLE && !q.scl_s2 && !timed_out) begin
			n.tocnt = q.tocnt + TW'(1);
		end else begin
			n.tocnt = '0;
		end
		if (start_seen) begin
			n.st = ST_ADDR;
			n.bitcnt = 4'h0;
			n.oe = 1'b0;
			n.bytenum = 2'd0;
		end else if (stop_seen || timed_out) begin
			n.st = ST_IDLE;
			n.oe = 1'b0;
		end else begin
			case (q.st)
				ST_ADDR, ST_RX: begin
					if (scl_rise && q.bitcnt != BITS_PER_BYTE) begin
						n.shreg = {q.shreg[6:0], q.sda_s2};
						n.bitcnt = q.bitcnt + 4'h1;
					end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
						if (q.st == ST_ADDR) begin
							if (q.shreg[7:1] == {TARGET_PREFIX, q.strap_s2}) begin
								n.st = ST_ADDR_ACK;
								n.oe = 1'b1;
								n.rd = q.shreg[0];
							end else begin
								n.st = ST_IDLE;
							end
						end else begin
							n.st = ST_RX_ACK;
							n.oe = 1'b1;
							if (q.bytenum != 2'd3) begin
								n.bytenum = q.bytenum + 2'd1;
							end
							case (q.bytenum)
								2'd0: n.index = q.shreg;
								2'd1: n.hold = q.shreg;
								2'd2: begin
									// Read-only and unmapped indices ignore the word
									if (q.index == IDX_CONTROL) begin
										n.ctrl = {q.hold, q.shreg};
									end else if (q.index == IDX_UPPER) begin
										n.upper = {q.hold, q.shreg};
									end else if (q.index == IDX_LOWER) begin
										n.lower = {q.hold, q.shreg};
									end else if (q.index == IDX_CRIT) begin
										n.crit = {q.hold, q.shreg};
									end else if (q.index == IDX_STEP) begin
										n.step = {q.hold, q.shreg};
									end
								end
								default: begin
								end
							endcase
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						n.bitcnt = 4'h0;
						if (q.rd) begin
							// Read starts at the kept pointer, upper byte first
							n.st = ST_TX;
							n.shreg = rd_word[15:8];
							n.oe = ~rd_word[15];
							n.bytenum = 2'd1;
						end else begin
							n.st = ST_RX;
							n.oe = 1'b0;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						n.st = ST_RX;
						n.oe = 1'b0;
						n.bitcnt = 4'h0;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (q.bitcnt == LAST_TX_BIT) begin
							n.st = ST_TX_ACK;
							n.oe = 1'b0;
						end else begin
							n.shreg = {q.shreg[6:0], 1'b0};
							n.oe = ~q.shreg[6];
							n.bitcnt = q.bitcnt + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						n.acked = ~q.sda_s2;
					end else if (scl_fall) begin
						if (q.acked && q.bytenum[0]) begin
							// Lower byte follows only an acked upper byte
							n.st = ST_TX;
							n.bitcnt = 4'h0;
							n.shreg = rd_word[7:0];
							n.oe = ~rd_word[7];
							n.bytenum = 2'd0;
						end else begin
							// Word done or nack: either ends output so a stop can follow
							n.st = ST_IDLE;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.scl_s3 <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_s3 <= 1'b1;
			q.st <= ST_IDLE;
			q.ctrl <= CONTROL_RESET;
			q.upper <= LIMIT_RESET;
			q.lower <= LIMIT_RESET;
			q.crit <= LIMIT_RESET;
			q.temp <= TEMP_RESET;
			q.step <= STEP_RESET;
		end else begin
			q <= n;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign sensor_sleep_control = q.ctrl[SLEEP_BIT];

	// ----------------------------------------------------------------
	// Event pin
	// ----------------------------------------------------------------
	event_pin_ctrl i_event_pin_ctrl (
		.clk(clk),
		.rst(rst),
		.sleep(sleeping),
		.event_in_shutdown_flag(FEATURE_RESET[SHUTDOWN_EVENT_BIT]),
		.comparator_mode(~q.ctrl[EVENT_MODE_BIT]),
		.sample_strobe(temp_valid & ~sleeping),
		.event_request(event_request & ~sleeping),
		.event_active(event_active),
		.event_oe(event_oe)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_addr_miss;
		@(posedge clk) disable iff (rst)
		(q.st == ST_ADDR && scl_fall && q.bitcnt == BITS_PER_BYTE && !start_seen && !stop_seen && !timed_out
			&& q.shreg[7:1] != {TARGET_PREFIX, q.strap_s2}) |=> (q.st == ST_IDLE && !q.oe);
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

	property p_word_write;
		@(posedge clk) disable iff (rst)
		(q.st == ST_RX && scl_fall && q.bitcnt == BITS_PER_BYTE && q.bytenum == 2'd2 && q.index == IDX_UPPER
			&& !start_seen && !stop_seen && !timed_out) |=> (q.upper == {$past(q.hold), $past(q.shreg)});
	endproperty
	a_word_write: assert property (p_word_write) else $error("word write not stored");

	property p_pointer_kept;
		@(posedge clk) disable iff (rst) (q.st == ST_IDLE) |=> $stable(q.index);
	endproperty
	a_pointer_kept: assert property (p_pointer_kept) else $error("pointer changed between transfers");

	property p_upper_first;
		@(posedge clk) disable iff (rst)
		(q.st == ST_ADDR_ACK && scl_fall && q.rd && !start_seen && !stop_seen && !timed_out)
			|=> (q.shreg == $past(rd_word[15:8]) && q.oe == !$past(rd_word[15]));
	endproperty
	a_upper_first: assert property (p_upper_first) else $error("read did not start with upper byte");

	property p_nack_ends;
		@(posedge clk) disable iff (rst)
		(q.st == ST_TX_ACK && scl_fall && (!q.acked || !q.bytenum[0]) && !start_seen && !stop_seen && !timed_out)
			|=> (q.st == ST_IDLE && !q.oe) [*2];
	endproperty
	a_nack_ends: assert property (p_nack_ends) else $error("data output not ended after nack");

	property p_feature_value;
		@(posedge clk) disable iff (rst) (q.index == IDX_FEATURE) |-> (rd_word == FEATURE_RESET && rd_word[15:8] == 8'h00);
	endproperty
	a_feature_value: assert property (p_feature_value) else $error("feature register value wrong");

	property p_sleep_freeze;
		@(posedge clk) disable iff (rst) sleeping |=> $stable(q.temp);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("temperature updated while asleep");

	property p_timeout;
		@(posedge clk) disable iff (rst) (timed_out && !start_seen) |=> (q.st == ST_IDLE && !q.oe);
	endproperty
	a_timeout: assert property (p_timeout) else $error("bus timeout did not release");

endmodule
`default_nettype wire

//--- core/thermal_sensor_pkg.sv
// Constants shared by the temperature monitor register access logic.
// Assumes a single 125 MHz clock and an asynchronous active-high reset.
package thermal_sensor_pkg;

	// ----------------------------------------------------------------
	// Clock and bus timeout
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TIMEOUT_US = 30000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Target address and register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] TARGET_PREFIX = 4'h3;
	localparam logic [7:0] IDX_FEATURE = 8'h00;
	localparam logic [7:0] IDX_CONTROL = 8'h01;
	localparam logic [7:0] IDX_UPPER = 8'h02;
	localparam logic [7:0] IDX_LOWER = 8'h03;
	localparam logic [7:0] IDX_CRIT = 8'h04;
	localparam logic [7:0] IDX_TEMP = 8'h05;
	localparam logic [7:0] IDX_MAKER = 8'h06;
	localparam logic [7:0] IDX_PART = 8'h07;
	localparam logic [7:0] IDX_STEP = 8'h08;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [15:0] FEATURE_RESET = 16'h006f;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [15:0] STEP_RESET = 16'h002f;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam int SHUTDOWN_EVENT_BIT = 7;
	localparam int TIMEOUT_WINDOW_BIT = 6;
	localparam int SLEEP_BIT = 8;
	localparam int EVENT_MODE_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// ----------------------------------------------------------------
	// Serial target states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_ADDR = 7'b000_0010,
		ST_ADDR_ACK = 7'b000_0100,
		ST_RX = 7'b000_1000,
		ST_RX_ACK = 7'b001_0000,
		ST_TX = 7'b010_0000,
		ST_TX_ACK = 7'b100_0000
	} bus_state_t;

endpackage

//--- core/event_pin_ctrl.sv
// Event pin driver with freeze or release behaviour across sleep.
// Assumes the event request comes from comparator logic on clk.
`timescale 1ns/1ps
`default_nettype none
module event_pin_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic sleep,
	input wire logic event_in_shutdown_flag,
	input wire logic comparator_mode,
	input wire logic sample_strobe,
	input wire logic event_request,
	output logic event_active,
	output logic event_oe
);
	typedef struct packed {
		logic level;
		logic oe;
		logic hold;
	} ev_state_t;

	ev_state_t q;
	ev_state_t n;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		if (sleep) begin
			n.hold = 1'b1;
			if (event_in_shutdown_flag) begin
				n.level = 1'b0;
				n.oe = 1'b0;
			end
		end else if (!q.hold || sample_strobe || comparator_mode) begin
			// Held state ends on a new sample or at once in comparator mode
			n.hold = 1'b0;
			n.level = event_request;
			n.oe = event_request;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign event_active = q.level;
	assign event_oe = q.oe;

	property p_release_on_sleep;
		@(posedge clk) disable iff (rst) (sleep && event_in_shutdown_flag) |=> !event_oe;
	endproperty
	a_release_on_sleep: assert property (p_release_on_sleep) else $error("event pin not released in sleep");

	property p_freeze_on_sleep;
		@(posedge clk) disable iff (rst) (sleep && !event_in_shutdown_flag) |=> ($stable(event_oe) && $stable(event_active));
	endproperty
	a_freeze_on_sleep: assert property (p_freeze_on_sleep) else $error("event pin moved while frozen");

endmodule
`default_nettype wire

//--- tb/bus_master_model.sv
// Two-wire bus controller model: drives SCL, pulls SDA low.
// Assumes pull-ups on both lines; the bench resolves SDA.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
	parameter int Q = 6
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// ----------------------------------------------------------------
	// Bus phases
	// ----------------------------------------------------------------
	// Idle high; a released line reads back the pull-up level
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Changes land just after an edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Start or repeated start; leaves SCL low
	task automatic start();
		scl = 1'b0;
		tick(Q);
		sda_low = 1'b0;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sda_low = 1'b1;
		tick(Q);
		scl = 1'b0;
		tick(Q);
	endtask

	// Stop may follow any byte
	task automatic stop();
		scl = 1'b0;
		sda_low = 1'b1;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sda_low = 1'b0;
		tick(2 * Q);
	endtask

	// Data held through the whole high phase
	task automatic bit_cycle(input logic b, output logic r);
		sda_low = ~b;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		r = sda;
		tick(Q);
		scl = 1'b0;
		tick(Q);
	endtask

	// Byte out, then the target's acknowledge
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
		bit_cycle(1'b1, r);
		ack = ~r;
	endtask

	// Byte in, then our ack or nack
	task automatic byte_in(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, r);
			d[i] = r;
		end
		bit_cycle(~ack, r);
	endtask
endmodule
`default_nettype wire

//--- tb/thermal_sensor_reg_access_test.sv
// Self-checking bench for the temperature monitor register access.
// Assumes bus_master_model on the far side of the serial pins.
`timescale 1ns/1ps
`default_nettype none
module thermal_sensor_reg_access_test;
	import thermal_sensor_pkg::*;
	// ----------------------------------------------------------------
	// Clock, pins, design and controller
	// ----------------------------------------------------------------
	localparam logic [15:0] MK = 16'h4d21; // Arbitrary value
	localparam logic [15:0] PT = 16'h7e03; // Arbitrary value
	localparam int TO = 200;
	logic clk = 1'b0;
	logic rst;
	logic [2:0] strap;
	logic temp_valid;
	logic [15:0] temp_sample;
	logic event_request;
	logic acks = 1'b1;
	logic sda_out, sda_oe, event_active, event_oe, sleep, scl, m_low;
	wire logic sda;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [15:0] d;
	logic [15:0] rv [9];
	logic [15:0] wv [9];

	// Open drain with pull-up; unknowns stay visible
	assign sda = ~((sda_oe & ~sda_out) | m_low);
	always #4 clk = ~clk;

	thermal_sensor_reg_access #(.TIMEOUT_CYC(TO), .MAKER_CODE(MK), .PART_CODE(PT)) i_thermal_sensor_reg_access (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]),
		.temp_valid(temp_valid), .temp_sample(temp_sample), .event_request(event_request),
		.event_active(event_active), .event_oe(event_oe), .sensor_sleep_control(sleep));
	bus_master_model i_bus_master_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

	// ----------------------------------------------------------------
	// Transfer tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Acks gather over a transfer, checked once
	task automatic ack_chk();
		chk(16'(acks), 16'h0001);
		acks = 1'b1;
	endtask

	task automatic put(input logic [7:0] b);
		logic a;
		i_bus_master_model.byte_out(b, a);
		acks = acks & a;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] v, input int nb);
		i_bus_master_model.start();
		put({4'b0011, strap, 1'b0});
		put(idx);
		if (nb > 0) put(v[15:8]);
		if (nb > 1) put(v[7:0]);
		i_bus_master_model.stop();
		ack_chk();
	endtask

	task automatic rd(output logic [15:0] v, input logic fin);
		logic [7:0] h, l;
		i_bus_master_model.start();
		put({4'b0011, strap, 1'b1});
		i_bus_master_model.byte_in(1'b1, h);
		i_bus_master_model.byte_in(fin, l);
		i_bus_master_model.stop();
		v = {h, l};
		ack_chk();
	endtask

	// Index preset, repeated start, word read
	task automatic rdi(input logic [7:0] idx, output logic [15:0] v);
		i_bus_master_model.start();
		put({4'b0011, strap, 1'b0});
		put(idx);
		rd(v, 1'b0);
	endtask

	task automatic probe(input logic [6:0] a, input logic exp);
		logic r;
		i_bus_master_model.start();
		i_bus_master_model.byte_out({a, 1'b0}, r);
		i_bus_master_model.stop();
		chk(16'(r), 16'(exp));
	endtask

	task automatic pulse(input logic [15:0] s);
		temp_sample = s;
		temp_valid = 1'b1;
		i_bus_master_model.tick(1);
		temp_valid = 1'b0;
	endtask

	task automatic test_done();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Watchdog at 80k cycles, well beyond the expected 47k
	initial begin
		#640_000;
		n_mismatch++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		strap = 3'b101;
		temp_valid = 1'b0;
		temp_sample = 16'h0000;
		event_request = 1'b0;
		rv = '{16'h006f, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, MK, PT, 16'h002f};
		for (int i = 0; i < 9; i++) wv[i] = {4'h6, 4'(i), 4'h9, 4'(i)};
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		i_bus_master_model.tick(4);
		for (int i = 0; i < 9; i++) begin
			rdi(8'(i), d);
			chk(d, rv[i]);
		end
		// Read-only places keep their value
		for (int i = 0; i < 9; i++) wr(8'(i), wv[i], 2);
		for (int i = 0; i < 9; i++) begin
			rdi(8'(i), d);
			chk(d, (i inside {0, 5, 6, 7}) ? rv[i] : wv[i]);
		end
		// Cut short after the upper byte: nothing stored
		wr(8'h02, 16'h1234, 1);
		rd(d, 1'b1);
		chk(d, wv[2]);
		rd(d, 1'b0);
		chk(d, wv[2]);
		// Straps read live; near misses refused
		for (int s = 0; s < 8; s++) begin
			strap = 3'(s);
			i_bus_master_model.tick(4);
			probe({4'b0011, 3'(s)}, 1'b1);
			probe({4'b0011, 3'(s) ^ 3'b001}, 1'b0);
			probe({4'b0111, 3'(s)}, 1'b0);
		end
		// Awake: sample lands, event follows request
		wr(8'h01, 16'h0000, 2);
		pulse(16'h0194);
		event_request = 1'b1;
		i_bus_master_model.tick(3);
		chk({14'h0, event_active, event_oe}, 16'h0003);
		rdi(IDX_TEMP, d);
		chk(d, 16'h0194);
		// Asleep: event frozen, samples ignored, bus served
		wr(8'h01, 16'h0100, 2);
		event_request = 1'b0;
		pulse(16'h0aa4);
		i_bus_master_model.tick(3);
		chk({13'h0, sleep, event_active, event_oe}, 16'h0007);
		rdi(IDX_TEMP, d);
		chk(d, 16'h0194);
		// SCL held low mid-read while asleep gets released
		wr(8'h01, 16'h0000, 0);
		i_bus_master_model.start();
		put({4'b0011, strap, 1'b1});
		i_bus_master_model.tick(6);
		chk(16'(sda_oe), 16'h0001);
		i_bus_master_model.tick(TO + 50);
		chk(16'(sda_oe), 16'h0000);
		i_bus_master_model.stop();
		ack_chk();
		// Wake in comparator mode: event follows at once
		wr(8'h01, 16'h0000, 2);
		i_bus_master_model.tick(3);
		chk({14'h0, event_active, event_oe}, 16'h0000);
		// Interrupt mode: level frozen in sleep is kept after wake until a sample
		wr(8'h01, 16'h0001, 2);
		event_request = 1'b1;
		i_bus_master_model.tick(3);
		chk({14'h0, event_active, event_oe}, 16'h0003);
		wr(8'h01, 16'h0101, 2);
		event_request = 1'b0;
		wr(8'h01, 16'h0001, 2);
		i_bus_master_model.tick(3);
		chk({14'h0, event_active, event_oe}, 16'h0003);
		pulse(16'h0190);
		i_bus_master_model.tick(3);
		chk({14'h0, event_active, event_oe}, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
